//--- pgs_pkg.sv
// constants for the i2c digital page store
// Operation
// - erase clears a whole page, never a block
// - erased page blocks are written independently
// - one 64-bit block is smallest unit
// - address is 11-bit page plus 5-bit block
// - device acknowledges each data byte written within the page
// - block bytes travel most significant first
// - partial block leaves remaining bytes zero
// - erased page reads back as zero
// - device buffers at most two blocks
// - device holds scl low while buffer full
// - overflow raises interrupt and nacks byte
// - early command is stretched until write done
// - write command 0xc9 then high, low address
// - erase command 0xd1 then address bytes
// - row end strobe pulses low per row
// - interrupt holds until status read clears it
package pgs_pkg;
   // bus bytes
   localparam logic [7:0] PGS_DEV_WR = 8'h80;
   localparam logic [7:0] PGS_DEV_RD = 8'h81;
   localparam logic [7:0] PGS_CMD_ENTER = 8'hC0;
   localparam logic [7:0] PGS_CMD_EXIT = 8'h40;
   localparam logic [7:0] PGS_CMD_WRITE = 8'hC9;
   localparam logic [7:0] PGS_CMD_PAGE_CLEAR = 8'hD1;
   // address layout
   localparam int PGS_PAGE_W = 11;
   localparam int PGS_BLK_W = 5;
   localparam int PGS_ADR_W = 16;
   localparam int PGS_BLK_BITS = 64;
   localparam logic [4:0] PGS_LAST_BLK = 5'h1F;
   localparam logic [2:0] PGS_LAST_BYTE = 3'h7;
   // status byte fields
   localparam int PGS_ST_FULL = 7;
   localparam int PGS_ST_DIG = 6;
   localparam int PGS_ST_BUSY = 5;
   // timing
   localparam int PGS_CORE_NS = 10;
   localparam int PGS_PROG_NS = 32000;
   localparam int PGS_PROG_CYC = (PGS_PROG_NS + PGS_CORE_NS - 1) / PGS_CORE_NS;
   localparam int PGS_ROW_LOW_NS = 250000;
   localparam int PGS_ROW_LOW_CYC =
      (PGS_ROW_LOW_NS + PGS_CORE_NS - 1) / PGS_CORE_NS;
endpackage

//--- pgs_store_mem.sv
// block memory of the page store, one 64-bit word per block
`timescale 1ns/1ps
module pgs_store_mem
   import pgs_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic we,
   input wire logic [PGS_ADR_W-1:0] wa,
   input wire logic [PGS_BLK_BITS-1:0] wd,
   input wire logic re,
   input wire logic [PGS_ADR_W-1:0] ra,
   output logic [PGS_BLK_BITS-1:0] rd_q
);
   // storage array, no reset
   logic [PGS_BLK_BITS-1:0] mem [0:(1<<PGS_ADR_W)-1];

   // write port
   always_ff @(posedge core_clk) begin
      if (we) begin
         mem[wa] <= wd;
      end
   end

   // registered read port
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q <= '0;
      end else if (re) begin
         rd_q <= mem[ra];
      end
   end
endmodule

//--- pgs_page_store.sv
// i2c digital page store: link-side protocol, core-side array engine
`timescale 1ns/1ps
module pgs_page_store
   import pgs_pkg::*;
#(
   parameter int ROW_LOW_CYC = PGS_ROW_LOW_CYC
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic scl_i,
   output logic scl_oe_n,
   input wire logic sda_i,
   output logic sda_oe_n,
   output logic int_oe_n,
   output logic row_end_oe_n,
   input wire logic rd_en,
   input wire logic [PGS_ADR_W-1:0] rd_adr,
   output logic [PGS_BLK_BITS-1:0] rd_data
);
   // link protocol states
   typedef enum logic [2:0] {
      L_IDLE = 3'b000,
      L_DEV = 3'b001,
      L_CMD = 3'b010,
      L_ADRH = 3'b011,
      L_ADRL = 3'b100,
      L_DATA = 3'b101,
      L_SEND = 3'b110,
      L_SKIP = 3'b111
   } pgs_lst_t;

   // core engine states
   typedef enum logic [1:0] {
      C_IDLE = 2'b00,
      C_PROG = 2'b01,
      C_CLR = 2'b10,
      C_STROBE = 2'b11
   } pgs_cst_t;

   // ---------------- link domain ----------------
   logic scl_s1, scl_s2, scl_s3; // scl synchroniser and history
   logic sda_s1, sda_s2, sda_s3; // sda synchroniser and history
   logic busy_s1, busy_s2; // core busy level
   logic ack_s1, ack_s2; // handshake acknowledge toggle
   logic cack_q; // core acknowledge toggle
   logic busy_q; // core busy level for link side
   logic rel_q; // scl kept low one cycle past a decision
   pgs_lst_t lst_q; // protocol state
   logic [3:0] bit_q; // bit counter in byte
   logic [7:0] sh_q; // receive shifter
   logic [7:0] tx_q; // status transmit shifter
   logic rdy_q; // full byte awaiting decision
   logic hold_q; // scl held low
   logic ack_q; // in acknowledge slot
   logic sda_lo_q; // pulling sda low
   logic dig_q; // digital mode active
   logic erase_q; // current command is erase
   logic [PGS_ADR_W-1:0] adr_q; // page and block address
   logic [2:0] byte_q; // byte index within block
   logic [PGS_BLK_BITS-1:0] blk_q; // block under assembly
   logic end_q; // last block of page handed over
   logic int_q; // store_full_flag, interrupt
   logic flush_q; // partial block waiting for handover
   logic req_q; // handshake request toggle
   logic [PGS_BLK_BITS-1:0] ho_d_q; // handover data
   logic [PGS_ADR_W-1:0] ho_a_q; // handover address
   logic ho_e_q; // handover is an erase
   logic rise, fall, start, stop, pend, stall;
   logic [PGS_BLK_BITS-1:0] blk_nx;

   // pin synchronisers, two flops then history
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_s3 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_s3 <= 1'b1;
      end else begin
         scl_s1 <= scl_i;
         scl_s2 <= scl_s1;
         scl_s3 <= scl_s2;
         sda_s1 <= sda_i;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
      end
   end

   // core level and toggle brought into link domain
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_s1 <= 1'b0;
         busy_s2 <= 1'b0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         busy_s1 <= busy_q;
         busy_s2 <= busy_s1;
         ack_s1 <= cack_q;
         ack_s2 <= ack_s1;
      end
   end

   // bus events
   assign rise = scl_s2 & ~scl_s3;
   assign fall = ~scl_s2 & scl_s3;
   assign start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   assign stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
   assign pend = req_q != ack_s2;
   // msb first: byte 0 lands in the top bits
   assign blk_nx = blk_q | ({56'h0, sh_q} << {~byte_q, 3'b000});

   // conditions that keep scl stretched
   always_comb begin
      stall = 1'b0;
      case (lst_q)
         // hold new command while core busy
         L_DEV: stall = busy_s2 | pend | flush_q;
         L_ADRL: stall = erase_q & pend;
         // hold while buffer cannot take block
         L_DATA: stall = (byte_q == PGS_LAST_BYTE) & ~end_q & pend;
         default: stall = 1'b0;
      endcase
   end

   // protocol engine
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         lst_q <= L_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         rdy_q <= 1'b0;
         hold_q <= 1'b0;
         ack_q <= 1'b0;
         sda_lo_q <= 1'b0;
         dig_q <= 1'b0;
         erase_q <= 1'b0;
         adr_q <= '0;
         byte_q <= 3'h0;
         blk_q <= '0;
         end_q <= 1'b0;
         int_q <= 1'b0;
         flush_q <= 1'b0;
         req_q <= 1'b0;
         ho_d_q <= '0;
         ho_a_q <= '0;
         ho_e_q <= 1'b0;
      end else if (start) begin
         // start or repeated start
         lst_q <= L_DEV;
         bit_q <= 4'h0;
         rdy_q <= 1'b0;
         hold_q <= 1'b0;
         ack_q <= 1'b0;
         sda_lo_q <= 1'b0;
      end else if (stop) begin
         lst_q <= L_IDLE;
         rdy_q <= 1'b0;
         hold_q <= 1'b0;
         ack_q <= 1'b0;
         sda_lo_q <= 1'b0;
         // short block goes out zero filled
         if (lst_q == L_DATA && byte_q != 3'h0) begin
            flush_q <= 1'b1;
         end
      end else if (flush_q && !pend) begin
         // partial block handover after stop
         ho_d_q <= blk_q;
         ho_a_q <= adr_q;
         ho_e_q <= 1'b0;
         req_q <= ~req_q;
         flush_q <= 1'b0;
      end else if (hold_q && !stall) begin
         // byte decision, release scl, enter ack slot
         hold_q <= 1'b0;
         rdy_q <= 1'b0;
         ack_q <= 1'b1;
         sda_lo_q <= 1'b0;
         case (lst_q)
            L_DEV: begin
               if (sh_q == PGS_DEV_WR) begin
                  sda_lo_q <= 1'b1;
                  lst_q <= L_CMD;
               end else if (sh_q == PGS_DEV_RD) begin
                  sda_lo_q <= 1'b1;
                  tx_q <= '0;
                  tx_q[PGS_ST_FULL] <= int_q;
                  tx_q[PGS_ST_DIG] <= dig_q;
                  tx_q[PGS_ST_BUSY] <= busy_s2;
                  int_q <= 1'b0;
                  lst_q <= L_SEND;
               end else begin
                  lst_q <= L_SKIP;
               end
            end
            L_CMD: begin
               lst_q <= L_SKIP;
               if (sh_q == PGS_CMD_ENTER) begin
                  sda_lo_q <= 1'b1;
                  dig_q <= 1'b1;
               end else if (sh_q == PGS_CMD_EXIT) begin
                  sda_lo_q <= 1'b1;
                  dig_q <= 1'b0;
               end else if (dig_q && (sh_q == PGS_CMD_WRITE ||
                                      sh_q == PGS_CMD_PAGE_CLEAR)) begin
                  sda_lo_q <= 1'b1;
                  erase_q <= sh_q == PGS_CMD_PAGE_CLEAR;
                  lst_q <= L_ADRH;
               end
            end
            L_ADRH: begin
               sda_lo_q <= 1'b1;
               adr_q[15:8] <= sh_q;
               lst_q <= L_ADRL;
            end
            L_ADRL: begin
               sda_lo_q <= 1'b1;
               adr_q[7:0] <= sh_q;
               byte_q <= 3'h0;
               blk_q <= '0;
               end_q <= 1'b0;
               if (erase_q) begin
                  ho_a_q <= {adr_q[15:8], sh_q};
                  ho_e_q <= 1'b1;
                  req_q <= ~req_q;
                  lst_q <= L_SKIP;
               end else begin
                  lst_q <= L_DATA;
               end
            end
            L_DATA: begin
               if (end_q) begin
                  int_q <= 1'b1;
                  lst_q <= L_SKIP;
               end else begin
                  sda_lo_q <= 1'b1;
                  byte_q <= byte_q + 3'h1;
                  if (byte_q == PGS_LAST_BYTE) begin
                     ho_d_q <= blk_nx;
                     ho_a_q <= adr_q;
                     ho_e_q <= 1'b0;
                     req_q <= ~req_q;
                     blk_q <= '0;
                     if (adr_q[4:0] == PGS_LAST_BLK) begin
                        end_q <= 1'b1;
                     end else begin
                        adr_q <= adr_q + 16'h0001;
                     end
                  end else begin
                     blk_q <= blk_nx;
                  end
               end
            end
            default: lst_q <= L_SKIP;
         endcase
      end else if (fall && rdy_q) begin
         // stretch scl until byte is decided
         hold_q <= 1'b1;
      end else if (fall && ack_q) begin
         // end of ack slot, first status bit if reading
         ack_q <= 1'b0;
         bit_q <= 4'h0;
         sda_lo_q <= (lst_q == L_SEND) ? ~tx_q[7] : 1'b0;
      end else if (fall && lst_q == L_SEND) begin
         if (bit_q == 4'h8) begin
            sda_lo_q <= 1'b0;
            lst_q <= L_SKIP;
         end else begin
            sda_lo_q <= ~tx_q[6];
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end else if (rise && lst_q == L_SEND) begin
         bit_q <= bit_q + 4'h1;
      end else if (rise && !ack_q && lst_q != L_IDLE &&
                   lst_q != L_SKIP) begin
         sh_q <= {sh_q[6:0], sda_s2};
         bit_q <= bit_q + 4'h1;
         if (bit_q == 4'h7) begin
            rdy_q <= 1'b1;
         end
      end
   end

   // stretch tail: sda settles before scl is let go
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         rel_q <= 1'b0;
      end else begin
         rel_q <= hold_q;
      end
   end

   // open drain pins, enable low drives low
   assign scl_oe_n = ~(hold_q | rel_q);
   assign sda_oe_n = ~sda_lo_q;
   assign int_oe_n = ~int_q;

   // ---------------- core domain ----------------
   logic req_s1, req_s2; // request toggle synchroniser
   pgs_cst_t cst_q; // engine state
   logic [15:0] tmr_q; // program and strobe timer
   logic [PGS_PAGE_W-1:0] page_q; // page being erased
   logic [PGS_BLK_W-1:0] cblk_q; // block being cleared
   logic [PGS_BLK_BITS-1:0] buf_d_q [0:1]; // two block buffer
   logic [PGS_ADR_W-1:0] buf_a_q [0:1];
   logic wp_q, rp_q; // buffer pointers
   logic [1:0] cnt_q; // buffer fill
   logic cpend, take, push, pop;
   logic mem_we;
   logic [PGS_ADR_W-1:0] mem_wa;
   logic [PGS_BLK_BITS-1:0] mem_wd;

   // request toggle into core domain
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
      end else begin
         req_s1 <= req_q;
         req_s2 <= req_s1;
      end
   end

   assign cpend = req_s2 != cack_q;
   // only two blocks buffered, erase waits for idle
   assign take = cpend & (ho_e_q ? (cnt_q == 2'd0 && cst_q == C_IDLE)
                                 : (cnt_q != 2'd2));
   assign push = take & ~ho_e_q;
   assign pop = (cst_q == C_PROG) && (tmr_q == 16'h0000);

   // acknowledge and busy level
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cack_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         if (take) begin
            cack_q <= ~cack_q;
         end
         busy_q <= cpend | (cnt_q != 2'd0) | (cst_q != C_IDLE);
      end
   end

   // two entry block buffer
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'd0;
         buf_d_q[0] <= '0;
         buf_d_q[1] <= '0;
         buf_a_q[0] <= '0;
         buf_a_q[1] <= '0;
      end else begin
         if (push) begin
            buf_d_q[wp_q] <= ho_d_q;
            buf_a_q[wp_q] <= ho_a_q;
            wp_q <= ~wp_q;
         end
         if (pop) begin
            rp_q <= ~rp_q;
         end
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

   // array engine: program blocks, clear pages, strobe rows
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cst_q <= C_IDLE;
         tmr_q <= 16'h0000;
         page_q <= '0;
         cblk_q <= '0;
      end else begin
         case (cst_q)
            C_IDLE: begin
               if (take && ho_e_q) begin
                  // low block bits ignored on erase
                  page_q <= ho_a_q[15:5];
                  cblk_q <= '0;
                  cst_q <= C_CLR;
               end else if (cnt_q != 2'd0) begin
                  tmr_q <= 16'(PGS_PROG_CYC - 1);
                  cst_q <= C_PROG;
               end
            end
            C_PROG: begin
               if (tmr_q == 16'h0000) begin
                  cst_q <= C_IDLE;
               end else begin
                  tmr_q <= tmr_q - 16'h0001;
               end
            end
            C_CLR: begin
               cblk_q <= cblk_q + 5'h01;
               if (cblk_q == PGS_LAST_BLK) begin
                  tmr_q <= 16'(ROW_LOW_CYC - 1);
                  cst_q <= C_STROBE;
               end
            end
            default: begin
               if (tmr_q == 16'h0000) begin
                  cst_q <= C_IDLE;
               end else begin
                  tmr_q <= tmr_q - 16'h0001;
               end
            end
         endcase
      end
   end

   // row end strobe low after each erased row
   assign row_end_oe_n = cst_q != C_STROBE;

   // memory write select
   always_comb begin
      mem_we = pop | (cst_q == C_CLR);
      mem_wa = {page_q, cblk_q};
      mem_wd = '0;
      if (pop) begin
         // each block programmed on its own
         mem_wa = buf_a_q[rp_q];
         mem_wd = buf_d_q[rp_q];
      end
   end

   // cleared blocks hold zero for reads
   pgs_store_mem u_mem (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .we(mem_we),
      .wa(mem_wa),
      .wd(mem_wd),
      .re(rd_en),
      .ra(rd_adr),
      .rd_q(rd_data)
   );
endmodule

//--- pgs_page_store_props.sv
// port assertions for the i2c digital page store
`timescale 1ns/1ps
module pgs_page_store_props
   import pgs_pkg::*;
#(
   parameter int ROW_LOW_CYC = PGS_ROW_LOW_CYC
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic scl_i,
   input wire logic scl_oe_n,
   input wire logic sda_i,
   input wire logic sda_oe_n,
   input wire logic int_oe_n,
   input wire logic row_end_oe_n,
   input wire logic rd_en,
   input wire logic [PGS_ADR_W-1:0] rd_adr,
   input wire logic [PGS_BLK_BITS-1:0] rd_data
);
   // core cycles the row end strobe has stayed low
   int low_cnt_q;
   // count strobe low time, clear while high
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt_q <= 0;
      end else if (!row_end_oe_n) begin
         low_cnt_q <= low_cnt_q + 1;
      end else begin
         low_cnt_q <= 0;
      end
   end
   a_rd_reset_zero: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $rose(rst_n) |-> rd_data == '0)
      else $error("read data not zero after reset");
   a_rd_hold_value: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !rd_en |=> $stable(rd_data))
      else $error("read data moved without a read");
   a_row_low_len: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      $rose(row_end_oe_n) |-> low_cnt_q == ROW_LOW_CYC)
      else $error("row end strobe low time wrong");
   a_row_low_max: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      low_cnt_q <= ROW_LOW_CYC)
      else $error("row end strobe held low too long");
   a_link_reset_idle: assert property (
      @(posedge link_clk) disable iff (!rst_n)
      $rose(rst_n) |-> scl_oe_n && sda_oe_n && int_oe_n)
      else $error("link lines not released after reset");
   a_stretch_on_low: assert property (
      @(posedge link_clk) disable iff (!rst_n)
      $fell(scl_oe_n) |-> !$past(scl_i))
      else $error("clock pulled low while master held it high");
   a_sda_scl_low: assert property (
      @(posedge link_clk) disable iff (!rst_n)
      $changed(sda_oe_n) |-> !scl_i)
      else $error("data line moved while clock high");
   a_int_clear_ack: assert property (
      @(posedge link_clk) disable iff (!rst_n)
      $rose(int_oe_n) |-> !sda_oe_n || !$past(sda_oe_n))
      else $error("interrupt cleared outside status ack");
endmodule

//--- pgs_i2c_master.sv
// i2c bus master model driving the page store link
`timescale 1ns/1ps
module pgs_i2c_master (
   input wire logic core_clk,
   input wire logic scl,
   input wire logic sda,
   output logic scl_m,
   output logic sda_m
);
   localparam int QTR = 16; // third of a bit in core cycles
   localparam int HOLD_MAX = 30000; // longest wait on a held clock
   // both lines released at start
   initial begin
      scl_m = 1'b1;
      sda_m = 1'b1;
   end
   // step n cycles, land just after the edge
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic scl_up();
      int n;
      n = 0;
      scl_m = 1'b1;
      while (scl !== 1'b1 && n < HOLD_MAX) begin
         wt(1);
         n++;
      end
   endtask
   // one clock pulse, sampling the data line while high
   task automatic bit_io(input logic b, output logic r);
      sda_m = b;
      wt(QTR);
      scl_up();
      wt(QTR);
      r = sda;
      scl_m = 1'b0;
      wt(QTR);
   endtask
   // start condition from an idle bus
   task automatic start();
      wt(QTR);
      sda_m = 1'b0;
      wt(QTR);
      scl_m = 1'b0;
      wt(QTR);
   endtask
   // stop condition, bus left idle
   task automatic stop();
      sda_m = 1'b0;
      wt(QTR);
      scl_up();
      wt(QTR);
      sda_m = 1'b1;
      wt(QTR);
   endtask
   task automatic put(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   // read one byte, then answer ack or nack
   task automatic get(input logic ack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         b[i] = r;
      end
      bit_io(~ack, r);
   endtask
endmodule

//--- pgs_page_store_bench.sv
// self-checking bench for the i2c digital page store
`timescale 1ns/1ps
module pgs_page_store_bench;
   import pgs_pkg::*;
   localparam int ROW_LOW_CYC = 20; // short strobe for simulation
   logic core_clk, link_clk, rst_n, rd_en; // driven inputs
   logic [PGS_ADR_W-1:0] rd_adr; // read address
   logic scl_m, sda_m, scl_oe_n, sda_oe_n, int_oe_n, row_end_oe_n;
   logic [PGS_BLK_BITS-1:0] rd_data; // read port result
   wire scl_w = scl_m & scl_oe_n; // pulled-up clock wire
   wire sda_w = sda_m & sda_oe_n; // pulled-up data wire
   int num_errors = 0;
   int checks_done = 0;
   int falls = 0; // row end strobe pulses seen
   logic [7:0] wb [24]; // bytes written, unsent ones zero
   pgs_page_store #(.ROW_LOW_CYC(ROW_LOW_CYC)) DUT (
      .core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk),
      .scl_i(scl_w), .scl_oe_n(scl_oe_n), .sda_i(sda_w),
      .sda_oe_n(sda_oe_n), .int_oe_n(int_oe_n),
      .row_end_oe_n(row_end_oe_n), .rd_en(rd_en), .rd_adr(rd_adr),
      .rd_data(rd_data));
   pgs_i2c_master u_master (.core_clk(core_clk), .scl(scl_w),
      .sda(sda_w), .scl_m(scl_m), .sda_m(sda_m));
   // clocks: core 10 ns, link 32 ns
   always #5 core_clk = ~core_clk;
   always #16 link_clk = ~link_clk;
   // count strobe pulses outside reset
   always @(negedge row_end_oe_n) begin
      if (rst_n === 1'b1) falls++;
   end
   // expected block k, first byte in the top bits
   function automatic logic [63:0] blk_exp(input int k);
      logic [63:0] v;
      v = '0;
      for (int i = 0; i < 8; i++) v = {v[55:0], wb[8*k+i]};
      return v;
   endfunction
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // send one byte and compare the answer
   task automatic tx(input logic [7:0] b, input logic ea);
      logic a;
      u_master.put(b, a);
      chk(a, ea);
   endtask
   // core read, data stands after the answer edge
   task automatic rd(input logic [15:0] a, output logic [63:0] d);
      rd_en = 1'b1;
      rd_adr = a;
      wt(1);
      rd_en = 1'b0;
      wt(1);
      d = rd_data;
   endtask
   task automatic enter();
      u_master.start();
      tx(PGS_DEV_WR, 1'b1);
      tx(PGS_CMD_ENTER, 1'b1);
      u_master.stop();
   endtask
   // command header: address, command, high and low address
   task automatic hdr(input logic [7:0] cmd, input logic [15:0] a);
      u_master.start();
      tx(PGS_DEV_WR, 1'b1);
      tx(cmd, 1'b1);
      tx(a[15:8], 1'b1);
      tx(a[7:0], 1'b1);
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // watchdog well beyond the expected run
   initial begin
      #800000;
      num_errors++;
      final_report();
   end
   initial begin
      logic [63:0] d;
      logic [10:0] pg;
      logic [4:0] bk;
      logic [7:0] st;
      core_clk = 1'b0;
      link_clk = 1'b0;
      rst_n = 1'b1;
      rd_en = 1'b0;
      rd_adr = '0;
      void'($urandom(32'h88F7));
      // clean falling edge so every async reset fires
      #1;
      rst_n = 1'b0;
      wt(3);
      rst_n = 1'b1;
      wt(1);
      chk({scl_oe_n, sda_oe_n, int_oe_n, row_end_oe_n}, 4'hF);
      chk(rd_data, 64'h0);
      wt(4);
      $display("test reset done");
      // two whole blocks and a three-byte tail
      // this page holds digital data only
      pg = 11'($urandom);
      bk = 5'($urandom_range(29));
      for (int i = 0; i < 24; i++) wb[i] = 8'h00;
      enter();
      hdr(PGS_CMD_WRITE, {pg, bk});
      for (int i = 0; i < 19; i++) begin
         wb[i] = (i == 0) ? 8'hFF : (i == 1) ? 8'h01 : 8'($urandom);
         tx(wb[i], 1'b1);
      end
      u_master.stop();
      // early command is held until programming ends
      u_master.start();
      tx(PGS_DEV_WR, 1'b1);
      tx(PGS_CMD_EXIT, 1'b1);
      u_master.stop();
      u_master.start();
      tx(PGS_DEV_WR, 1'b1);
      tx(PGS_CMD_WRITE, 1'b0);
      u_master.stop();
      wt(2 * PGS_PROG_CYC);
      // written blocks read back before the page is erased
      for (int k = 0; k < 3; k++) begin
         rd({pg, 5'(bk + k)}, d);
         chk(d, blk_exp(k));
      end
      $display("test block write done");
      // erase names the page, block bits zero
      enter();
      hdr(PGS_CMD_PAGE_CLEAR, {pg, 5'h00});
      u_master.stop();
      wt(200);
      chk(falls, 1);
      for (int k = 0; k < 32; k++) begin
         rd({pg, 5'(k)}, d);
         chk(d, 64'h0);
      end
      $display("test page erase done");
      // last block of the page, then one byte too many
      // rewrite only after the page erase
      hdr(PGS_CMD_WRITE, {pg, PGS_LAST_BLK});
      for (int i = 0; i < 8; i++) begin
         wb[i] = 8'($urandom);
         tx(wb[i], 1'b1);
      end
      tx(8'($urandom), 1'b0);
      wt(4);
      chk(int_oe_n, 1'b0);
      u_master.stop();
      wt(PGS_PROG_CYC + 100);
      rd({pg, PGS_LAST_BLK}, d);
      chk(d, blk_exp(0));
      u_master.start();
      tx(PGS_DEV_RD, 1'b1);
      u_master.get(1'b0, st);
      u_master.stop();
      chk(st[PGS_ST_FULL], 1'b1);
      chk(st[PGS_ST_DIG], 1'b1);
      chk(st[PGS_ST_BUSY], 1'b0);
      chk(int_oe_n, 1'b1);
      $display("test overflow done");
      final_report();
   end
endmodule
bind pgs_page_store pgs_page_store_props #(.ROW_LOW_CYC(ROW_LOW_CYC)) u_props (
   .core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk),
   .scl_i(scl_i), .scl_oe_n(scl_oe_n), .sda_i(sda_i),
   .sda_oe_n(sda_oe_n), .int_oe_n(int_oe_n),
   .row_end_oe_n(row_end_oe_n), .rd_en(rd_en), .rd_adr(rd_adr),
   .rd_data(rd_data));
